// ==== dpi_pkg.sv ====
// Purpose: shared constants and types for the dram pin interface
// Assumes: core clock clk at 250 MHz, synchronous active-low reset
// Notes: bus clock is derived from clk; edge select comes from a board pin
// What this block does
// - supports 8, 16, 32-bit DRAM, 512 Mbytes
// - two active-low row strobes, chip selects
// - four active-low column strobes, also byte masks
// - strobe 3 is lsb lane, 0 msb
// - write output low during write cycles
// - column command output driven from register
// - row command output driven from register
// - clock enable output driven from register
// - edge select high: change on rising
// - edge select low: change on falling
// - loop-back clock: change on its rising
// - bus clock is half, third, quarter
package dpi_pkg;
    localparam int ADDR_W          = 29;   // 512 Mbytes of byte address
    localparam int LANES           = 4;
    localparam logic [1:0] DIV_QUARTER = 2'h0;
    localparam logic [1:0] DIV_HALF    = 2'h2;
    localparam logic [1:0] DIV_THIRD   = 2'h3;
    localparam logic [1:0] PORT_32     = 2'h0;
    localparam logic [1:0] PORT_8      = 2'h1;
    localparam logic [1:0] PORT_16     = 2'h2;
    localparam logic [1:0] HALF_PER_Q  = 2'h2;  // core cycles per bus clock half
    localparam logic [1:0] HALF_LO_T   = 2'h1;  // third ratio: low half 1, high 2
    localparam logic [1:0] HALF_HI_T   = 2'h2;
    localparam logic [1:0] HALF_PER_H  = 2'h1;
    localparam logic [1:0] SYNC_SETTLE = 2'h2;  // edges out of reset before straps are read

    typedef enum logic [1:0] {
        EDGE_RISE,
        EDGE_FALL,
        EDGE_LOOP
    } dpi_edge_t;

    // one command word from the controller core
    typedef struct packed {
        logic       row_cmd_n;
        logic       col_cmd_n;
        logic       clk_en;
        logic       write_n;
        logic [1:0] block_sel_n;
        logic [3:0] lane_n;        // index 3 is the lsb lane
    } dpi_cmd_t;
endpackage

// ==== dpi_sync.sv ====
// Purpose: two flip-flop synchroniser for board inputs
// Assumes: inputs come from outside the clk domain
// Notes: only the second stage is read outside
`timescale 1ns/10ps
`default_nettype none
module dpi_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } dpi_sync_state_t;

    dpi_sync_state_t st_reg;
    dpi_sync_state_t st_next;

    // first stage feeds only the second
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;
endmodule
`default_nettype wire

// ==== dpi_top.sv ====
// Purpose: dram pin stage with bus clock and sdram edge select
// Assumes: cmd held by the core until cmd_taken; edge select is static except in loop mode, where it carries the loop clock
// Notes: pins update once per bus clock on the selected edge; the edge
//        mode is latched a few edges after reset and then held until the
//        next reset, so no command is taken in those first edges
`timescale 1ns/10ps
`default_nettype none
module dpi_top (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic [1:0]      div_sel,
    input  wire logic [1:0]      port_size,
    input  wire logic            sync_mode,
    input  wire logic            cmd_valid,
    input  wire dpi_pkg::dpi_cmd_t cmd,
    input  wire logic [dpi_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic            sdram_edge_select,
    input  wire logic            edge_loop_mode,
    output logic                 cmd_taken,
    output logic                 bus_clock_out,
    output logic [1:0]           row_strobe_n,
    output logic [3:0]           column_strobe_n,
    output logic                 column_strobe_lsb_lane,
    output logic                 column_strobe_msb_lane,
    output logic                 dram_write_n,
    output logic                 sdram_column_cmd_n,
    output logic                 sdram_row_cmd_n,
    output logic                 sdram_clock_enable,
    output logic [dpi_pkg::ADDR_W-1:0] dram_addr
);
    ////////////////////////////////////////////////////////////////////
    // timing in core cycles, for the half ratio and a rising update edge:
    //   c0  bus clock low, last core cycle of the low half, cmd_valid high
    //   c1  bus clock high, pins show the command, cmd_taken high
    //   c2  cmd_taken low again; the core drops or changes its command
    // falling mode takes the command at the last cycle of the high half.
    // loop mode takes it where the synchronised loop clock first reads
    // high, two to three core cycles after the board clock rose; that lag
    // is the price of sampling the loop clock like any other pin.
    // async dram always uses the rising edge, whatever the strap says.
    // the core must keep cmd_valid and cmd still until cmd_taken, and a
    // narrow port gets its unused lanes forced idle here, not in the core.

    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [1:0]                 cnt;
        logic                       bclk;
        logic                       loop_prev;
        dpi_pkg::dpi_edge_t         mode;
        logic                       mode_ok;
        logic [1:0]                 settle;     // synchroniser flush count
        dpi_pkg::dpi_cmd_t          pins;
        logic [dpi_pkg::ADDR_W-1:0] addr;
        logic                       taken;
    } dpi_state_t;

    dpi_state_t st_reg;
    dpi_state_t st_next;
    logic       edge_pin_s;
    logic       loop_pin_s;
    logic [1:0] half_len;
    logic       bclk_rise;
    logic       bclk_fall;
    logic       upd;
    logic [3:0] lane_mask;
    logic [2:0] lanes_used;
    logic       half_end;
    logic       settled;
    // candidate pin words for a taken command and for an idle edge
    dpi_pkg::dpi_cmd_t pins_take;
    dpi_pkg::dpi_cmd_t pins_idle;

    ////////////////////////////////////////////////////////////////////
    // board inputs cross into clk via two flops
    dpi_sync u_edge_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (sdram_edge_select),
        .q     (edge_pin_s)
    );

    dpi_sync u_loop_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (edge_loop_mode),
        .q     (loop_pin_s)
    );

    ////////////////////////////////////////////////////////////////////
    // length of current bus clock half in core cycles
    always_comb begin
        if (div_sel == dpi_pkg::DIV_HALF) begin
            half_len = dpi_pkg::HALF_PER_H;
        end else if (div_sel == dpi_pkg::DIV_THIRD) begin
            half_len = st_reg.bclk ? dpi_pkg::HALF_HI_T : dpi_pkg::HALF_LO_T;
        end else begin
            half_len = dpi_pkg::HALF_PER_Q; // reserved code runs as quarter
        end
    end

    // last core cycle of the current half; the bus clock flips next edge
    assign half_end  = (st_reg.cnt == half_len - 2'h1);
    assign bclk_rise = half_end && !st_reg.bclk;
    assign bclk_fall = half_end && st_reg.bclk;

    ////////////////////////////////////////////////////////////////////
    // bytes the port carries; port size 3 is treated as a full width port
    always_comb begin
        lanes_used = 3'h4;
        if (port_size == dpi_pkg::PORT_8) begin
            lanes_used = 3'h1;
        end else if (port_size == dpi_pkg::PORT_16) begin
            lanes_used = 3'h2;
        end
    end

    // one enable per strobe; the lsb lane sits at index 3, so a narrow
    // port uses the top indices and leaves the msb lanes idle
    for (genvar g = 0; g < dpi_pkg::LANES; g++) begin : g_lane
        assign lane_mask[g] = (3'(dpi_pkg::LANES - 1 - g) < lanes_used);
    end

    ////////////////////////////////////////////////////////////////////
    // pin words for a taken command and for an idle update edge
    always_comb begin
        pins_take        = cmd;
        pins_take.lane_n = cmd.lane_n | ~lane_mask;
        // idle deselects every block but keeps clock enable, so a gap in
        // the command stream never wakes an sdram held in power-down
        pins_idle             = st_reg.pins;
        pins_idle.row_cmd_n   = 1'b1;
        pins_idle.col_cmd_n   = 1'b1;
        pins_idle.write_n     = 1'b1;
        pins_idle.block_sel_n = 2'h3;
        pins_idle.lane_n      = 4'hF;
    end

    ////////////////////////////////////////////////////////////////////
    // the synchronisers sit in reset with everything else, so the straps
    // only show at their outputs two edges after release; latching the
    // mode any earlier would read every strap as low and always pick the
    // falling edge, whatever the board does
    assign settled = (st_reg.settle == dpi_pkg::SYNC_SETTLE);

    ////////////////////////////////////////////////////////////////////
    // pick the update edge for the selected mode
    always_comb begin
        case (st_reg.mode)
            dpi_pkg::EDGE_RISE: upd = bclk_rise;
            dpi_pkg::EDGE_FALL: upd = bclk_fall;
            dpi_pkg::EDGE_LOOP: upd = edge_pin_s && !st_reg.loop_prev;
            default:            upd = bclk_rise;
        endcase
        // async dram strobes follow the bus clock rising edge always
        if (!sync_mode) begin
            upd = bclk_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next           = st_reg;
        st_next.taken     = 1'b0;
        st_next.loop_prev = edge_pin_s;
        if (half_end) begin
            st_next.cnt  = 2'h0;
            st_next.bclk = !st_reg.bclk;
        end else begin
            st_next.cnt = st_reg.cnt + 2'h1;
        end
        // mode latched once the straps are through the synchronisers; no
        // command is taken before, and later strap changes wait for reset
        if (!st_reg.mode_ok) begin
            if (!settled) begin
                st_next.settle = st_reg.settle + 2'h1;
            end else begin
                st_next.mode_ok = 1'b1;
                if (loop_pin_s) begin
                    st_next.mode = dpi_pkg::EDGE_LOOP;
                end else if (edge_pin_s) begin
                    st_next.mode = dpi_pkg::EDGE_RISE;
                end else begin
                    st_next.mode = dpi_pkg::EDGE_FALL;
                end
            end
        end else if (upd) begin
            if (cmd_valid) begin
                st_next.pins  = pins_take;
                st_next.addr  = cmd_addr;
                st_next.taken = 1'b1;
            end else begin
                st_next.pins = pins_idle;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg             <= '0;
            st_reg.mode        <= dpi_pkg::EDGE_RISE;
            st_reg.pins        <= '1;
            st_reg.pins.clk_en <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops
    assign cmd_taken              = st_reg.taken;
    assign bus_clock_out          = st_reg.bclk;
    assign row_strobe_n           = st_reg.pins.block_sel_n;
    assign column_strobe_n        = st_reg.pins.lane_n;
    assign column_strobe_lsb_lane = st_reg.pins.lane_n[3];
    assign column_strobe_msb_lane = st_reg.pins.lane_n[0];
    assign dram_write_n           = st_reg.pins.write_n;
    assign sdram_column_cmd_n     = st_reg.pins.col_cmd_n;
    assign sdram_row_cmd_n        = st_reg.pins.row_cmd_n;
    assign sdram_clock_enable     = st_reg.pins.clk_en;
    assign dram_addr              = st_reg.addr;
endmodule
`default_nettype wire

// ==== dpi_top_sva.sv ====
// Purpose: checker for the dram pin stage
// Assumes: modes static between resets
// Notes: bound into dpi_top below
`timescale 1ns/10ps
`default_nettype none
module dpi_chk (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [1:0]        div_sel,
    input wire logic [1:0]        port_size,
    input wire logic              sync_mode,
    input wire dpi_pkg::dpi_cmd_t cmd,
    input wire logic              sdram_edge_select,
    input wire logic              edge_loop_mode,
    input wire logic              cmd_taken,
    input wire logic              bus_clock_out,
    input wire logic [1:0]        row_strobe_n,
    input wire logic [3:0]        column_strobe_n,
    input wire logic              column_strobe_lsb_lane,
    input wire logic              column_strobe_msb_lane,
    input wire logic              dram_write_n,
    input wire logic              sdram_column_cmd_n,
    input wire logic              sdram_row_cmd_n,
    input wire logic              sdram_clock_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // pins follow the command sampled one edge before the pulse
    lane_copy_a: assert property (column_strobe_lsb_lane == column_strobe_n[3]
        && column_strobe_msb_lane == column_strobe_n[0]) else $error("lane copy wrong");
    row_cmd_a: assert property (cmd_taken && sync_mode |->
        sdram_row_cmd_n == $past(cmd.row_cmd_n)) else $error("row command wrong");
    col_cke_a: assert property (cmd_taken && sync_mode |-> sdram_clock_enable ==
        $past(cmd.clk_en) && sdram_column_cmd_n == $past(cmd.col_cmd_n)) else $error("cmd bad");
    write_dir_a: assert property (cmd_taken |->
        dram_write_n == $past(cmd.write_n)) else $error("write level wrong");
    row_strobe_a: assert property (cmd_taken |->
        row_strobe_n == $past(cmd.block_sel_n)) else $error("row strobe wrong");
    narrow_mask_a: assert property (cmd_taken && port_size == dpi_pkg::PORT_8 |->
        column_strobe_n[2:0] == 3'h7) else $error("unused lanes active");
    // update edge placement against the bus clock
    rise_edge_a: assert property (cmd_taken && !edge_loop_mode && (sdram_edge_select
        || !sync_mode) |-> $rose(bus_clock_out)) else $error("not on rising edge");
    fall_edge_a: assert property (cmd_taken && sync_mode && !sdram_edge_select
        && !edge_loop_mode |-> $fell(bus_clock_out)) else $error("not on falling edge");
    quarter_ratio_a: assert property (div_sel == dpi_pkg::DIV_QUARTER && $rose(bus_clock_out)
        |=> bus_clock_out ##1 $fell(bus_clock_out)) else $error("quarter ratio wrong");
endmodule
bind dpi_top dpi_chk chk_i (.*);
`default_nettype wire

// ==== dpi_sdram_model.sv ====
// Purpose: board side model feeding the edge select pin
// Assumes: loop clock is the buffered bus clock
// Notes: strap level is used when loop mode is off
`timescale 1ns/10ps
`default_nettype none
module dpi_sdram_model (
    input  wire logic bus_clock_out,
    input  wire logic loop_en,
    input  wire logic strap_level,
    output logic      edge_pin
);
    logic buf_clk;
    // board buffer adds a slight phase lag
    always @(bus_clock_out) buf_clk <= #1.5 bus_clock_out;
    // strap stays fixed, or looped, between resets
    assign edge_pin = loop_en ? buf_clk : strap_level;
endmodule
`default_nettype wire

// ==== dpi_top_tb.sv ====
// Purpose: scenario bench for the dram pin stage
// Assumes: one command per bus clock, modes set during reset
// Notes: loop clock comes from the board model
`timescale 1ns/10ps
`default_nettype none
module dpi_top_tb;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [1:0]        div_sel = 2'h2;
    logic [1:0]        port_size = 2'h0;
    logic              sync_mode = 1'b1;
    logic              cmd_valid = 1'b0;
    dpi_pkg::dpi_cmd_t cmd = 10'h3FF;
    logic [28:0]       cmd_addr = 29'h0;
    logic              strap = 1'b1;
    logic              edge_loop_mode = 1'b0;
    logic              sdram_edge_select, cmd_taken, bus_clock_out, dram_write_n, seen_bco;
    logic              column_strobe_lsb_lane, column_strobe_msb_lane, sdram_clock_enable;
    logic              sdram_column_cmd_n, sdram_row_cmd_n;
    logic [1:0]        row_strobe_n;
    logic [3:0]        column_strobe_n;
    logic [28:0]       dram_addr;
    int                num_errors = 0;
    int                check_count = 0;
    dpi_top dut (.*);
    dpi_sdram_model model (.bus_clock_out, .loop_en(edge_loop_mode), .strap_level(strap),
        .edge_pin(sdram_edge_select));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // modes only change under reset; synchronisers need the settle time
    task automatic restart(input logic [1:0] dv, input logic [1:0] ps, input logic sm,
        input logic lv, input logic lp);
        @(posedge clk);
        rst_n <= 1'b0;
        div_sel <= dv;
        port_size <= ps;
        sync_mode <= sm;
        strap <= lv;
        edge_loop_mode <= lp;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic send(input dpi_pkg::dpi_cmd_t c, input logic [28:0] a, input logic [3:0] col);
        int n;
        @(posedge clk);
        cmd <= c;
        cmd_addr <= a;
        cmd_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (cmd_taken !== 1'b1 && n < 64);
        // a command never taken fails the command taken check and the pin checks after it; the run still reaches the report
        if (n == 64) begin
            chk("command taken", 1, cmd_taken);
        end
        seen_bco = bus_clock_out;
        chk("row strobe", c.block_sel_n, row_strobe_n);
        chk("column strobe", col, column_strobe_n);
        chk("lsb lane", col[3], column_strobe_lsb_lane);
        chk("msb lane", col[0], column_strobe_msb_lane);
        chk("write", c.write_n, dram_write_n);
        chk("address", a, dram_addr);
        if (sync_mode) begin
            chk("column cmd", c.col_cmd_n, sdram_column_cmd_n);
            chk("row cmd", c.row_cmd_n, sdram_row_cmd_n);
            chk("clock enable", c.clk_en, sdram_clock_enable);
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    // write then read, one idle bus clock between them, rising update edge
    task automatic s_write_rise;
        restart(dpi_pkg::DIV_HALF, dpi_pkg::PORT_32, 1'b1, 1'b1, 1'b0);
        send(10'h190, 29'h1FFFFFFF, 4'h0);
        chk("rise edge", 1, seen_bco);
        send(10'h2E5, 29'h0000155, 4'h5);
    endtask
    // read at the falling update edge, third ratio
    task automatic s_read_fall;
        restart(dpi_pkg::DIV_THIRD, dpi_pkg::PORT_32, 1'b1, 1'b0, 1'b0);
        send(10'h2E6, 29'h0000AAA, 4'h6);
        chk("fall edge", 0, seen_bco);
    endtask
    // narrow ports keep unused lanes idle
    task automatic s_narrow;
        restart(dpi_pkg::DIV_QUARTER, dpi_pkg::PORT_8, 1'b0, 1'b1, 1'b0);
        send(10'h3A0, 29'h0000003, 4'h7);
        chk("async edge", 1, seen_bco);
        restart(dpi_pkg::DIV_QUARTER, dpi_pkg::PORT_16, 1'b1, 1'b1, 1'b0);
        send(10'h3A0, 29'h0000002, 4'h3);
    endtask
    // loop-back clock from the board
    task automatic s_loop;
        restart(dpi_pkg::DIV_HALF, dpi_pkg::PORT_32, 1'b1, 1'b0, 1'b1);
        send(10'h190, 29'h0000040, 4'h0);
    endtask
    initial begin
        s_write_rise();
        s_read_fall();
        s_narrow();
        s_loop();
        close_out();
    end
endmodule
`default_nettype wire
